// >>> hdl/gpm_pkg.sv
// Package: register map, field layout, reset values and carriers of the GPIO upper bank
package gpm_pkg;
   localparam int GPM_PINS = 15;
   localparam int GPM_FW = 3;
   // Register byte offsets
   localparam logic [7:0] GPM_OFS_DATA = 8'h00;
   localparam logic [7:0] GPM_OFS_DIR = 8'h04;
   localparam logic [7:0] GPM_OFS_SENSE = 8'h10;
   localparam logic [7:0] GPM_OFS_BOTH = 8'h14;
   localparam logic [7:0] GPM_OFS_POL = 8'h18;
   localparam logic [7:0] GPM_OFS_IEN = 8'h1c;
   localparam logic [7:0] GPM_OFS_MIS = 8'h24;
   localparam logic [7:0] GPM_OFS_ACK = 8'h28;
   localparam logic [7:0] GPM_OFS_FUNC_LO = 8'h2c;
   localparam logic [7:0] GPM_OFS_FUNC_HI = 8'h30;
   localparam logic [7:0] GPM_OFS_SET = 8'h3c;
   localparam logic [7:0] GPM_OFS_CLR = 8'h40;
   localparam logic [7:0] GPM_OFS_TMR = 8'h44;
   // Reset values
   localparam logic [31:0] GPM_RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] GPM_RST_FUNC_HI = 32'h0000_0110;
   localparam logic [31:0] GPM_RST_TMR = 32'h0000_0000;
   // Valid-bit masks of the function words
   localparam logic [31:0] GPM_MASK_FUNC_LO = 32'h7777_7777;
   localparam logic [31:0] GPM_MASK_FUNC_HI = 32'h0777_7777;
   // Function codes
   typedef enum logic [2:0] {
      GPM_FN_GPIO = 3'h0,
      GPM_FN_SER1 = 3'h1,
      GPM_FN_SER0 = 3'h4,
      GPM_FN_SER2 = 3'h5
   } gpm_fn_e;
   // AXI responses
   localparam logic [1:0] GPM_RESP_OKAY = 2'h0;
   localparam logic [1:0] GPM_RESP_SLVERR = 2'h2;
   // Pin-side signals of one function
   typedef struct packed {
      logic [14:0] out;
      logic [14:0] oe;
   } gpm_drive_s;
   // Timer capture input selections
   typedef struct packed {
      logic [7:0] t2_b;
      logic [7:0] t2_a;
      logic [7:0] t1_b;
      logic [7:0] t1_a;
   } gpm_tmr_sel_s;
endpackage : gpm_pkg

// >>> hdl/gpm_irq_detect.sv
// Per-pin interrupt detector with sticky pending bits and acknowledge
`timescale 1ns/1ps
module gpm_irq_detect #(
   parameter int PINS = 15
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pin levels and configuration
   input wire logic [PINS-1:0] pin_lvl,
   input wire logic [PINS-1:0] sense_level,
   input wire logic [PINS-1:0] both_edges,
   input wire logic [PINS-1:0] polarity_high,
   // Acknowledge strobe
   input wire logic [PINS-1:0] ack,
   // Raw pending bits
   output logic [PINS-1:0] pending
);
   logic [PINS-1:0] prev_r; // Last sampled level
   logic [PINS-1:0] event_w; // Qualifying event this cycle
   logic [PINS-1:0] pend_r; // Sticky pending

   initial begin
      if (PINS < 1 || PINS > 32) $error("gpm_irq_detect: PINS out of range");
   end

   // Event qualification per pin
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (sense_level[i]) begin
            event_w[i] = (pin_lvl[i] == polarity_high[i]);
         end else if (both_edges[i]) begin
            event_w[i] = pin_lvl[i] ^ prev_r[i];
         end else begin
            event_w[i] = (pin_lvl[i] ^ prev_r[i]) & (pin_lvl[i] == polarity_high[i]);
         end
      end
   end

   // Previous level for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) prev_r <= '0;
      else prev_r <= pin_lvl;
   end

   // Sticky pending; new event beats acknowledge so nothing is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) pend_r <= '0;
      else pend_r <= (pend_r & ~ack) | event_w;
   end

   assign pending = pend_r;
endmodule : gpm_irq_detect

// >>> hdl/gpm_port.sv
// GPIO port: interrupt status, pin function select, bit set/clear, timer input routing
//
// Function
// - Read-only masked status, one bit per pin
// - Acknowledge write of one clears pending bit
// - Low function word, pins 0-7, nibbles
// - High function word, pins 8-14, 9/10 reset 1
// - Set word forces data bits of GPIO-mode pins to one
// - Clear word forces data bits of GPIO-mode pins to zero
// - Four byte-wide timer input pin selectors
// - Codes select GPIO, serial one, zero, two
// - Data drives GPIO outputs, reads pin levels
// - Masked status is pending AND enable
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module gpm_port
   import gpm_pkg::*;
#(
   parameter int PINS = 15
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe,
   // Serial functions driving pins when selected
   input wire gpm_pkg::gpm_drive_s serial_function_zero,
   input wire gpm_pkg::gpm_drive_s serial_function_one,
   input wire gpm_pkg::gpm_drive_s serial_function_two,
   // Timer capture inputs
   output logic [3:0] timer_capture_in,
   output gpm_pkg::gpm_tmr_sel_s timer_input_routing
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [PINS-1:0] data_r; // Output data latch
   logic [PINS-1:0] dir_r; // One = output
   logic [PINS-1:0] sense_r; // One = level sensing
   logic [PINS-1:0] both_r; // One = both edges
   logic [PINS-1:0] pol_r; // One = rising/high
   logic [PINS-1:0] ien_r; // irq_enable_word
   logic [31:0] func_lo_r; // pin_function_low
   logic [31:0] func_hi_r; // pin_function_high
   logic [31:0] tmr_r; // timer_input_routing
   logic [PINS-1:0] pending; // Raw pending from detector
   logic [PINS-1:0] ack_w; // Acknowledge pulse
   logic [PINS-1:0] gpio_mode; // Pin in GPIO mode
   logic [2:0] code [PINS]; // Function code per pin
   logic [7:0] aw_addr_r; // Held write address
   logic aw_have_r; // Write address captured
   logic [31:0] w_data_r; // Held write data
   logic [3:0] w_strb_r; // Held strobes
   logic w_have_r; // Write data captured
   logic wr_go; // Both halves present
   logic [31:0] wmask; // Byte enables widened
   logic bvalid_r; // Write response pending
   logic [1:0] bresp_r; // Write response code
   logic rvalid_r; // Read data pending
   logic [31:0] rdata_r; // Read data
   logic [1:0] rresp_r; // Read response code
   logic [31:0] rd_val; // Decoded read value
   logic rd_ok; // Read address mapped

   // The serial drive carriers are fixed at fifteen pins, so wider ports cannot be served
   initial begin
      if (PINS < 9 || PINS > 15) $error("gpm_port: PINS must lie in 9..15");
   end

   // Widen pin vector into a 32-bit word, upper bits zero
   function automatic logic [31:0] widen(input logic [PINS-1:0] v);
      logic [31:0] w;
      w = '0;
      w[PINS-1:0] = v;
      return w;
   endfunction : widen

   // Merge write data into a register under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      return (old & ~m) | (nw & m);
   endfunction : merge

   // Merge write data into a pin-wide register; the slice goes through a variable
   function automatic logic [PINS-1:0] merge_pins(input logic [PINS-1:0] old,
                                                  input logic [31:0] nw, input logic [31:0] m);
      logic [31:0] w;
      w = merge(widen(old), nw, m);
      return w[PINS-1:0];
   endfunction : merge_pins

   // Is the address a mapped, writable register
   function automatic logic wr_mapped(input logic [7:0] a);
      case (a)
         GPM_OFS_DATA, GPM_OFS_DIR, GPM_OFS_SENSE, GPM_OFS_BOTH, GPM_OFS_POL, GPM_OFS_IEN,
         GPM_OFS_ACK, GPM_OFS_FUNC_LO, GPM_OFS_FUNC_HI, GPM_OFS_SET, GPM_OFS_CLR,
         GPM_OFS_TMR: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : wr_mapped

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready = !w_have_r && !bvalid_r;
   assign wr_go = aw_have_r && w_have_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_comb begin
      for (int b = 0; b < 4; b++) wmask[8*b +: 8] = {8{w_strb_r[b]}};
   end

   // Capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
         aw_have_r <= 1'b0;
      end
   end

   // Write data and strobes, held until the write completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
         w_have_r <= 1'b0;
      end
   end

   // Response one cycle after both halves are held; unmapped gets SLVERR
   // A low bready holds the response, and no new write is taken meanwhile
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= GPM_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped(aw_addr_r) ? GPM_RESP_OKAY : GPM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register writes
   // Output data: plain write, then set/clear only on GPIO-mode pins
   // Set/clear on serial pins is dropped, so a serial drive is never disturbed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_r <= GPM_RST_ZERO[PINS-1:0];
      end else if (wr_go && aw_addr_r == GPM_OFS_DATA) begin
         data_r <= merge_pins(data_r, w_data_r, wmask);
      end else if (wr_go && aw_addr_r == GPM_OFS_SET) begin
         data_r <= data_r | (w_data_r[PINS-1:0] & wmask[PINS-1:0] & gpio_mode);
      end else if (wr_go && aw_addr_r == GPM_OFS_CLR) begin
         data_r <= data_r & ~(w_data_r[PINS-1:0] & wmask[PINS-1:0] & gpio_mode);
      end
   end

   // Direction and interrupt configuration words
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_r <= GPM_RST_ZERO[PINS-1:0];
         sense_r <= GPM_RST_ZERO[PINS-1:0];
         both_r <= GPM_RST_ZERO[PINS-1:0];
         pol_r <= GPM_RST_ZERO[PINS-1:0];
         ien_r <= GPM_RST_ZERO[PINS-1:0];
      end else if (wr_go) begin
         case (aw_addr_r)
            GPM_OFS_DIR: dir_r <= merge_pins(dir_r, w_data_r, wmask);
            GPM_OFS_SENSE: sense_r <= merge_pins(sense_r, w_data_r, wmask);
            GPM_OFS_BOTH: both_r <= merge_pins(both_r, w_data_r, wmask);
            GPM_OFS_POL: pol_r <= merge_pins(pol_r, w_data_r, wmask);
            GPM_OFS_IEN: ien_r <= merge_pins(ien_r, w_data_r, wmask);
            default: ;
         endcase
      end
   end

   // Function select words; reserved bits forced to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         func_lo_r <= GPM_RST_ZERO;
         func_hi_r <= GPM_RST_FUNC_HI;
      end else if (wr_go && aw_addr_r == GPM_OFS_FUNC_LO) begin
         func_lo_r <= merge(func_lo_r, w_data_r, wmask) & GPM_MASK_FUNC_LO;
      end else if (wr_go && aw_addr_r == GPM_OFS_FUNC_HI) begin
         func_hi_r <= merge(func_hi_r, w_data_r, wmask) & GPM_MASK_FUNC_HI;
      end
   end

   // Timer input routing word
   always_ff @(posedge aclk) begin
      if (!aresetn) tmr_r <= GPM_RST_TMR;
      else if (wr_go && aw_addr_r == GPM_OFS_TMR) tmr_r <= merge(tmr_r, w_data_r, wmask);
   end

   // Acknowledge is a pulse, never stored
   assign ack_w = (wr_go && aw_addr_r == GPM_OFS_ACK) ?
                  (w_data_r[PINS-1:0] & wmask[PINS-1:0]) : '0;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Pin function multiplexing
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         code[i] = (i < 8) ? func_lo_r[4*i +: 3] : func_hi_r[4*(i-8) +: 3];
      end
   end

   // Each pin picks its driver by code; unknown codes leave the pin undriven
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         gpio_mode[i] = 1'b0;
         case (gpm_fn_e'(code[i]))
            GPM_FN_GPIO: begin
               gpio_mode[i] = 1'b1;
               pin_out[i] = data_r[i];
               pin_oe[i] = dir_r[i];
            end
            GPM_FN_SER1: begin
               pin_out[i] = serial_function_one.out[i];
               pin_oe[i] = serial_function_one.oe[i];
            end
            GPM_FN_SER0: begin
               pin_out[i] = serial_function_zero.out[i];
               pin_oe[i] = serial_function_zero.oe[i];
            end
            GPM_FN_SER2: begin
               pin_out[i] = serial_function_two.out[i];
               pin_oe[i] = serial_function_two.oe[i];
            end
            default: begin
               pin_out[i] = 1'b0;
               pin_oe[i] = 1'b0;
            end
         endcase
      end
   end

   // Timer capture inputs; an index beyond the last pin reads low
   assign timer_input_routing = gpm_tmr_sel_s'(tmr_r);
   always_comb begin
      for (int t = 0; t < 4; t++) begin
         timer_capture_in[t] = (tmr_r[8*t +: 8] < 8'(PINS)) ?
                               pin_in[tmr_r[8*t +: 4]] : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Interrupt detection
   gpm_irq_detect #(
      .PINS(PINS)
   ) u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_lvl(pin_in),
      .sense_level(sense_r),
      .both_edges(both_r),
      .polarity_high(pol_r),
      .ack(ack_w),
      .pending(pending)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   // Reads never stall: arready drops only while read data waits
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Read decode; write-only acknowledge reads zero
   always_comb begin
      rd_ok = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         GPM_OFS_DATA: rd_val = widen(pin_in);
         GPM_OFS_DIR: rd_val = widen(dir_r);
         GPM_OFS_SENSE: rd_val = widen(sense_r);
         GPM_OFS_BOTH: rd_val = widen(both_r);
         GPM_OFS_POL: rd_val = widen(pol_r);
         GPM_OFS_IEN: rd_val = widen(ien_r);
         GPM_OFS_MIS: rd_val = widen(pending & ien_r);
         GPM_OFS_ACK: rd_val = GPM_RST_ZERO;
         GPM_OFS_FUNC_LO: rd_val = func_lo_r;
         GPM_OFS_FUNC_HI: rd_val = func_hi_r;
         GPM_OFS_SET: rd_val = GPM_RST_ZERO;
         GPM_OFS_CLR: rd_val = GPM_RST_ZERO;
         GPM_OFS_TMR: rd_val = tmr_r;
         default: begin
            rd_val = GPM_RST_ZERO;
            rd_ok = 1'b0;
         end
      endcase
   end

   // Read data registered, answered the cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= GPM_RST_ZERO;
         rresp_r <= GPM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= rd_ok ? GPM_RESP_OKAY : GPM_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule : gpm_port

// >>> testbench/gpm_port_checker.sv
// Checker: bus handshake, reset pin drive and timer routing relations of the port
`timescale 1ns/1ps
module gpm_port_checker
   import gpm_pkg::*;
#(
   parameter int PINS = 15
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Pins and timer routing
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] pin_oe,
   input wire gpm_pkg::gpm_drive_s serial_function_one,
   input wire logic [3:0] timer_capture_in,
   input wire gpm_pkg::gpm_tmr_sel_s timer_input_routing
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////
   // High until a write address is taken, so register reset values still rule the pins
   logic no_wr_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         no_wr_r <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         no_wr_r <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////
   a_reset_pin_drive:
   assert property (no_wr_r |-> pin_oe == {4'h0, serial_function_one.oe[10:9], 9'h000})
      else $error("pin drive differs from reset functions");
   a_cap_first_a:
   assert property (timer_capture_in[0] == ((timer_input_routing.t1_a < 8'h0f) ?
      pin_in[timer_input_routing.t1_a[3:0]] : 1'b0)) else $error("first timer A input wrong");
   a_cap_second_b:
   assert property (timer_capture_in[3] == ((timer_input_routing.t2_b < 8'h0f) ?
      pin_in[timer_input_routing.t2_b[3:0]] : 1'b0)) else $error("second timer B input wrong");
   a_write_answer_time:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   a_read_answer_time:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_write_busy_refuse:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_busy_refuse:
   assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
   a_reset_idle_bus:
   assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid)
      else $error("response valid after reset");
endmodule : gpm_port_checker

bind gpm_port gpm_port_checker #(.PINS(PINS)) u_chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pin_in, .pin_oe,
   .serial_function_one, .timer_capture_in, .timer_input_routing
);

// >>> testbench/gpm_pin_model.sv
// Pin-side partner: external levels, resolved pin wire and serial peripheral drives
`timescale 1ns/1ps
module gpm_pin_model
   import gpm_pkg::*;
(
   // Wire levels
   input wire logic [14:0] pin_out,
   input wire logic [14:0] pin_oe,
   input wire logic [14:0] ext_lvl,
   output logic [14:0] pin_in,
   // Serial peripheral drives
   output gpm_pkg::gpm_drive_s serial_function_zero,
   output gpm_pkg::gpm_drive_s serial_function_one,
   output gpm_pkg::gpm_drive_s serial_function_two
);
   // Port wins where it drives, the outside world elsewhere
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
   // Distinct patterns so each function leaves its own mark on pins 0 and 1
   assign serial_function_zero = '{out: 15'h7fff, oe: 15'h5555};
   assign serial_function_one = '{out: 15'h0000, oe: 15'h7fff};
   assign serial_function_two = '{out: 15'h7fff, oe: 15'h2aaa};
endmodule : gpm_pin_model

// >>> testbench/tb_gpm_port.sv
// Testbench: register accesses and pin checks of the port's upper bank
`timescale 1ns/1ps
module tb_gpm_port;
   import gpm_pkg::*;
   // Clock, reset and bus master signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rdat;
   // Pins and peripherals
   logic [14:0] pin_in, pin_out, pin_oe;
   logic [14:0] ext_lvl = 15'h0;
   gpm_drive_s serial_function_zero, serial_function_one, serial_function_two;
   logic [3:0] timer_capture_in;
   gpm_tmr_sel_s timer_input_routing;
   // Bookkeeping
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] rst_addr [7] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c, 8'h40, 8'h44};
   logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'h0, 32'h110, 32'h0, 32'h0, 32'h0};
   logic [2:0] fn_code [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
   logic [3:0] fn_sig [4] = '{4'hd, 4'hc, 4'h5, 4'ha};
   ////////////////////////////////////////////////////////////
   gpm_port #(.PINS(15)) dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .serial_function_zero,
      .serial_function_one, .serial_function_two, .timer_capture_in, .timer_input_routing
   );
   gpm_pin_model u_pins (
      .pin_out, .pin_oe, .ext_lvl, .pin_in, .serial_function_zero, .serial_function_one,
      .serial_function_two
   );
   // 25 MHz clock
   always #20 aclk = ~aclk;
   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////
   // Write: both halves offered together, each dropped once taken, wait for response
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : wr
   // Read: address held until taken, data captured at the valid edge
   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : rd
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd(a);
      chk(rdat, exp, what);
      chk({30'h0, resp}, {30'h0, GPM_RESP_OKAY}, "read response");
   endtask : rchk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rchk(rst_addr[i], rst_val[i], "reset value");
      end
      // Unmapped places answer with an error
      wr(8'h08, 32'h1);
      chk({30'h0, resp}, {30'h0, GPM_RESP_SLVERR}, "unmapped write");
      rd(8'h0c);
      chk({30'h0, resp}, {30'h0, GPM_RESP_SLVERR}, "unmapped read");
      // Reserved function bits stay zero
      wr(GPM_OFS_FUNC_LO, 32'hffff_ffff);
      rchk(GPM_OFS_FUNC_LO, 32'h7777_7777, "low function mask");
      wr(GPM_OFS_FUNC_HI, 32'hffff_ffff);
      rchk(GPM_OFS_FUNC_HI, 32'h0777_7777, "high function mask");
      wr(GPM_OFS_FUNC_HI, 32'h110);
      chk({30'h0, resp}, {30'h0, GPM_RESP_OKAY}, "mapped write");
      // Every function code on pins 0 and 1
      wr(GPM_OFS_DIR, 32'h3);
      wr(GPM_OFS_DATA, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(GPM_OFS_FUNC_LO, {25'h0, fn_code[i], 1'b0, fn_code[i]});
         chk({28'h0, pin_oe[1:0], pin_out[1:0] & pin_oe[1:0]}, {28'h0, fn_sig[i]}, "fn");
      end
      // Set and clear act on general-purpose pins only
      wr(GPM_OFS_FUNC_LO, 32'h0);
      wr(GPM_OFS_DIR, 32'h7fff);
      wr(GPM_OFS_DATA, 32'h0);
      wr(GPM_OFS_SET, 32'h601);
      chk({17'h0, pin_out & 15'h79ff}, 32'h1, "set pins");
      wr(GPM_OFS_SET, 32'h7fff);
      wr(GPM_OFS_CLR, 32'h102);
      chk({17'h0, pin_out & 15'h79ff}, 32'h78fd, "clear pins");
      rchk(GPM_OFS_DATA, 32'h78fd, "pin levels");
      wr(GPM_OFS_FUNC_HI, 32'h0);
      chk({17'h0, pin_out}, 32'h78fd, "serial pins untouched");
      // Interrupts: rising edges on pins 2 and 3, only pin 2 enabled at first
      wr(GPM_OFS_DIR, 32'h0);
      wr(GPM_OFS_POL, 32'hc);
      wr(GPM_OFS_IEN, 32'h4);
      wr(GPM_OFS_ACK, 32'h7fff);
      ext_lvl <= 15'hc;
      rchk(GPM_OFS_MIS, 32'h4, "masked status");
      wr(GPM_OFS_IEN, 32'hc);
      rchk(GPM_OFS_MIS, 32'hc, "enable reveals pending");
      wr(GPM_OFS_ACK, 32'h4);
      rchk(GPM_OFS_MIS, 32'h8, "acknowledge one pin");
      wr(GPM_OFS_ACK, 32'h0);
      rchk(GPM_OFS_MIS, 32'h8, "acknowledge zero");
      wr(GPM_OFS_SENSE, 32'h8);
      wr(GPM_OFS_ACK, 32'h8);
      rchk(GPM_OFS_MIS, 32'h8, "event beats acknowledge");
      ext_lvl <= 15'h0;
      repeat (4) @(posedge aclk);
      wr(GPM_OFS_ACK, 32'h8);
      rchk(GPM_OFS_MIS, 32'h0, "level gone");
      // Both-edge sensing on pin 2 also catches the falling edge
      wr(GPM_OFS_BOTH, 32'h4);
      ext_lvl <= 15'h4;
      repeat (2) @(posedge aclk);
      wr(GPM_OFS_ACK, 32'h4);
      ext_lvl <= 15'h0;
      rchk(GPM_OFS_MIS, 32'h4, "falling edge caught");
      // Timer routing, first selector out of range
      wr(GPM_OFS_TMR, 32'h0e05_0320);
      rchk(GPM_OFS_TMR, 32'h0e05_0320, "routing word");
      chk(timer_input_routing, 32'h0e05_0320, "routing port");
      for (int i = 0; i < 2; i++) begin
         ext_lvl <= i ? 15'h3fd7 : 15'h4028;
         repeat (2) @(posedge aclk);
         chk({28'h0, timer_capture_in}, {28'h0, ext_lvl[14], ext_lvl[5], ext_lvl[3], 1'b0},
             "capture");
      end
      tally_and_finish();
   end
endmodule : tb_gpm_port
